// >>> rtl/clkgen_regs_pkg.sv
`default_nettype none

package clkgen_regs_pkg;

	// ==========================================================
	// Register map
	localparam logic [7:0] IDLE_LEVEL_ADDR = 8'h19;
	localparam logic [7:0] PLL_RESTART_ADDR = 8'hb1;
	localparam logic [7:0] CRYSTAL_LOAD_ADDR = 8'hb7;

	// ==========================================================
	// Reset values
	localparam logic [7:0] IDLE_LEVEL_RESET = 8'h00;
	localparam logic [7:0] PLL_RESTART_RESET = 8'h00;
	localparam logic [7:0] CRYSTAL_LOAD_RESET = 8'hc0;
	localparam logic [7:0] UNMAPPED_READ = 8'h00;

	// ==========================================================
	// Field positions
	localparam int SECOND_PLL_BIT = 7;
	localparam int FIRST_PLL_BIT = 5;
	localparam int CRYSTAL_FIELD_LSB = 6;
	localparam int IDLE_FIELD_WIDTH = 2;
	localparam int OUTPUT_COUNT = 4;
	localparam int SYNC_STAGES = 2;

	// ==========================================================
	// Field codes
	typedef enum logic [1:0] {
		IDLE_LOW = 2'h0,
		IDLE_HIGH = 2'h1,
		IDLE_HIGH_Z = 2'h2,
		IDLE_NEVER_DISABLED = 2'h3
	} output_idle_level_select_e;

	typedef enum logic [1:0] {
		CRYSTAL_LOAD_RESERVED = 2'h0,
		CRYSTAL_LOAD_6PF = 2'h1,
		CRYSTAL_LOAD_8PF = 2'h2,
		CRYSTAL_LOAD_10PF = 2'h3
	} crystal_load_select_e;

	// Link side request state, Gray ordered.
	typedef enum logic {
		LINK_IDLE = 1'b0,
		LINK_WAIT = 1'b1
	} link_state_e;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic we;
	} reg_req_s;

endpackage

`default_nettype wire

// >>> rtl/toggle_pulse_sync.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Toggle to pulse crossing
// The first stage feeds only the second; the edge is taken between the
// second and third stages so a metastable first stage cannot glitch it.
module toggle_pulse_sync (
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic i_toggle,
	output logic o_pulse
);

	logic meta;
	logic stable;
	logic last;

	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			meta <= 1'b0;
			stable <= 1'b0;
			last <= 1'b0;
		end
		else
		begin
			meta <= i_toggle;
			stable <= meta;
			last <= stable;
		end
	end

	assign o_pulse = stable ^ last;

endmodule // toggle_pulse_sync

`default_nettype wire

// >>> rtl/output_disable_pll_reset_regs.sv
`timescale 1ns/1ps
`default_nettype none

module output_disable_pll_reset_regs #(
	parameter bit HAS_SECOND_PLL = 1'b1
) (
	input wire logic i_core_clk,
	input wire logic i_rst_b,
	input wire logic i_link_clk,
	input wire logic i_link_req,
	input wire logic [7:0] i_link_addr,
	input wire logic [7:0] i_link_wdata,
	input wire logic i_link_we,
	output logic o_link_busy,
	output logic o_link_done,
	output logic [7:0] o_link_rdata,
	input wire logic [3:0] i_output_disable_reg,
	input wire logic i_output_disable_pin,
	input wire logic [3:0] i_clk_src,
	output logic [3:0] o_clk_out,
	output logic [3:0] o_clk_out_oe,
	output logic o_first_pll_restart,
	output logic o_second_pll_restart,
	output logic [1:0] o_crystal_load_select
);

	function automatic logic [1:0] idle_field(input logic [7:0] levels, input int idx);
		idle_field = levels[idx * clkgen_regs_pkg::IDLE_FIELD_WIDTH +: 2];
	endfunction

	// ==========================================================
	// Link domain: one request in flight, held until the core answers
	clkgen_regs_pkg::link_state_e link_state;
	clkgen_regs_pkg::reg_req_s req_held;
	logic req_toggle;
	logic ack_toggle;
	logic ack_pulse;
	logic req_pulse;
	logic [7:0] resp_data;

	assign o_link_busy = (link_state == clkgen_regs_pkg::LINK_WAIT);
	always_ff @(posedge i_link_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			link_state <= clkgen_regs_pkg::LINK_IDLE;
			req_held <= '0;
			req_toggle <= 1'b0;
			o_link_done <= 1'b0;
			o_link_rdata <= 8'h00;
		end
		else
		begin
			o_link_done <= 1'b0;
			case (link_state)
				clkgen_regs_pkg::LINK_IDLE:
				begin
					if (i_link_req)
					begin
						req_held <= '{addr: i_link_addr, wdata: i_link_wdata, we: i_link_we};
						req_toggle <= ~req_toggle;
						link_state <= clkgen_regs_pkg::LINK_WAIT;
					end
				end
				clkgen_regs_pkg::LINK_WAIT:
				begin
					if (ack_pulse)
					begin
						o_link_rdata <= resp_data;
						o_link_done <= 1'b1;
						link_state <= clkgen_regs_pkg::LINK_IDLE;
					end
				end
				default: link_state <= clkgen_regs_pkg::LINK_IDLE;
			endcase
		end
	end

	toggle_pulse_sync u_ack_sync (
		.i_clk(i_link_clk),
		.i_rst_b(i_rst_b),
		.i_toggle(ack_toggle),
		.o_pulse(ack_pulse)
	);
	toggle_pulse_sync u_req_sync (
		.i_clk(i_core_clk),
		.i_rst_b(i_rst_b),
		.i_toggle(req_toggle),
		.o_pulse(req_pulse)
	);

	// ==========================================================
	// Core domain register file
	// The held request stays put while its toggle crosses, so the pulse may read it.
	logic [7:0] clk_out_4_to_7_idle_level;
	logic [7:0] pll_restart_trigger;
	logic [7:0] crystal_load_capacitance;
	logic first_pending;
	logic second_pending;
	logic wr_idle;
	logic wr_pll;
	logic wr_xtal;
	logic set_first;
	logic set_second;
	logic [7:0] readback;

	assign wr_idle = req_pulse && req_held.we && req_held.addr == clkgen_regs_pkg::IDLE_LEVEL_ADDR;
	assign wr_pll = req_pulse && req_held.we && req_held.addr == clkgen_regs_pkg::PLL_RESTART_ADDR;
	assign wr_xtal = req_pulse && req_held.we && req_held.addr == clkgen_regs_pkg::CRYSTAL_LOAD_ADDR;
	assign set_first = wr_pll && req_held.wdata[clkgen_regs_pkg::FIRST_PLL_BIT];
	assign set_second = HAS_SECOND_PLL && wr_pll
		&& req_held.wdata[clkgen_regs_pkg::SECOND_PLL_BIT];

	always_comb
	begin
		case (req_held.addr)
			clkgen_regs_pkg::IDLE_LEVEL_ADDR:
				readback = clk_out_4_to_7_idle_level;
			clkgen_regs_pkg::PLL_RESTART_ADDR:
			begin
				readback = pll_restart_trigger;
				readback[clkgen_regs_pkg::FIRST_PLL_BIT] = first_pending;
				readback[clkgen_regs_pkg::SECOND_PLL_BIT] = second_pending;
			end
			clkgen_regs_pkg::CRYSTAL_LOAD_ADDR:
				readback = crystal_load_capacitance;
			default:
				readback = clkgen_regs_pkg::UNMAPPED_READ;
		endcase
	end

	always_ff @(posedge i_core_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			resp_data <= 8'h00;
			ack_toggle <= 1'b0;
		end
		else if (req_pulse)
		begin
			resp_data <= readback;
			ack_toggle <= ~ack_toggle;
		end
	end
	always_ff @(posedge i_core_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			clk_out_4_to_7_idle_level <= clkgen_regs_pkg::IDLE_LEVEL_RESET;
		else if (wr_idle)
			clk_out_4_to_7_idle_level <= req_held.wdata;
	end
	always_ff @(posedge i_core_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			crystal_load_capacitance <= clkgen_regs_pkg::CRYSTAL_LOAD_RESET;
		else if (wr_xtal)
			crystal_load_capacitance <= req_held.wdata;
	end
	assign o_crystal_load_select =
		crystal_load_capacitance[clkgen_regs_pkg::CRYSTAL_FIELD_LSB +: 2];

	// Restart bits live in the pending flops, so their stored copies stay zero.
	always_ff @(posedge i_core_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			pll_restart_trigger <= clkgen_regs_pkg::PLL_RESTART_RESET;
		else if (wr_pll)
		begin
			pll_restart_trigger <= req_held.wdata;
			pll_restart_trigger[clkgen_regs_pkg::FIRST_PLL_BIT] <= 1'b0;
			pll_restart_trigger[clkgen_regs_pkg::SECOND_PLL_BIT] <= 1'b0;
		end
	end

	// A new write that lands as the old request clears is kept: set wins.
	always_ff @(posedge i_core_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			first_pending <= 1'b0;
			second_pending <= 1'b0;
			o_first_pll_restart <= 1'b0;
			o_second_pll_restart <= 1'b0;
		end
		else
		begin
			first_pending <= set_first;
			second_pending <= set_second;
			o_first_pll_restart <= first_pending;
			o_second_pll_restart <= second_pending;
		end
	end

	// ==========================================================
	// Output disable
	logic [1:0] pin_sync;
	logic pin_disable;
	logic [3:0] disabled_q;
	logic [7:0] level_q;

	always_ff @(posedge i_core_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			pin_sync <= 2'h0;
		else
			pin_sync <= {pin_sync[0], i_output_disable_pin};
	end
	assign pin_disable = pin_sync[1];

	always_ff @(posedge i_core_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			disabled_q <= 4'h0;
			level_q <= clkgen_regs_pkg::IDLE_LEVEL_RESET;
		end
		else
		begin
			level_q <= clk_out_4_to_7_idle_level;
			for (int i = 0; i < clkgen_regs_pkg::OUTPUT_COUNT; i++)
				disabled_q[i] <= (i_output_disable_reg[i] || pin_disable)
					&& idle_field(clk_out_4_to_7_idle_level, i)
					!= clkgen_regs_pkg::IDLE_NEVER_DISABLED;
		end
	end

	// The clock itself passes combinationally; only the decision and the idle levels are registered.
	always_comb
	begin
		for (int i = 0; i < clkgen_regs_pkg::OUTPUT_COUNT; i++)
		begin
			o_clk_out[i] = disabled_q[i]
				? idle_field(level_q, i) == clkgen_regs_pkg::IDLE_HIGH : i_clk_src[i];
			o_clk_out_oe[i] = !(disabled_q[i]
				&& idle_field(level_q, i) == clkgen_regs_pkg::IDLE_HIGH_Z);
		end
	end

	// ==========================================================
	// Checks
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_b);
	sequence s_first_write;
		set_first;
	endsequence
	sequence s_first_pulse;
		first_pending ##1 o_first_pll_restart ##1 !o_first_pll_restart;
	endsequence
	a_idle_write: assert property (wr_idle |=>
		clk_out_4_to_7_idle_level == $past(req_held.wdata))
		else $error("idle level write lost");
	a_first_restart: assert property (s_first_write ##1 !set_first |-> s_first_pulse)
		else $error("first pll restart pulse wrong");
	a_second_restart: assert property (set_second |=> ##1 o_second_pll_restart)
		else $error("second pll restart missing");
	a_restart_cause: assert property ($rose(o_first_pll_restart) |-> $past(set_first, 2))
		else $error("first pll restart without write");
	a_restart_readback: assert property (o_first_pll_restart && !first_pending
		&& req_held.addr == clkgen_regs_pkg::PLL_RESTART_ADDR
		|-> readback[clkgen_regs_pkg::FIRST_PLL_BIT] == 1'b0)
		else $error("restart bit not cleared");
	a_crystal_write: assert property (wr_xtal |=>
		o_crystal_load_select == $past(req_held.wdata[7:6]))
		else $error("crystal load select not updated");
	a_pin_sync: assert property ($rose(i_output_disable_pin) ##1 i_output_disable_pin
		|=> pin_disable)
		else $error("disable pin not seen after sync");
	for (genvar g = 0; g < 4; g++)
	begin : g_out_checks
		a_never_disabled: assert property (
			idle_field(clk_out_4_to_7_idle_level, g) == clkgen_regs_pkg::IDLE_NEVER_DISABLED
			|=> !disabled_q[g])
			else $error("never-disabled output was disabled");
		a_reg_disable: assert property ((i_output_disable_reg[g] || pin_disable) &&
			idle_field(clk_out_4_to_7_idle_level, g) != clkgen_regs_pkg::IDLE_NEVER_DISABLED
			|=> disabled_q[g])
			else $error("output not disabled");
		a_idle_drive: assert property (disabled_q[g]
			|-> (o_clk_out[g] == (idle_field(level_q, g) == clkgen_regs_pkg::IDLE_HIGH))
			&& (o_clk_out_oe[g] == (idle_field(level_q, g) != clkgen_regs_pkg::IDLE_HIGH_Z)))
			else $error("idle drive level wrong");
	end

endmodule // output_disable_pll_reset_regs

`default_nettype wire

// >>> testbench/link_host_model.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Host side of the register link
// Released request lines carry inverted values, so a design that samples
// them outside the taking edge picks up wrong data.
module link_host_model (
	input wire logic i_link_clk,
	input wire logic i_link_busy,
	input wire logic i_link_done,
	input wire logic [7:0] i_link_rdata,
	output logic o_link_req,
	output logic [7:0] o_link_addr,
	output logic [7:0] o_link_wdata,
	output logic o_link_we
);
	initial
	begin
		o_link_req = 1'b0;
		o_link_addr = 8'h00;
		o_link_wdata = 8'h00;
		o_link_we = 1'b0;
	end

	task automatic access(input logic we, input logic [7:0] addr, input logic [7:0] wdata,
		input int gap, output logic [7:0] rdata, output bit ok);
		int n;
		ok = 1'b0;
		rdata = 8'h00;
		repeat (gap + 1) @(posedge i_link_clk);
		if (i_link_busy !== 1'b0)
		begin
			return;
		end
		o_link_req <= 1'b1;
		o_link_addr <= addr;
		o_link_wdata <= wdata;
		o_link_we <= we;
		@(posedge i_link_clk);
		o_link_req <= 1'b0;
		o_link_addr <= ~addr;
		o_link_wdata <= ~wdata;
		o_link_we <= ~we;
		for (n = 0; n < 20; n++)
		begin
			@(posedge i_link_clk);
			if (i_link_done === 1'b1)
			begin
				rdata = i_link_rdata;
				ok = 1'b1;
				break;
			end
		end
	endtask
endmodule // link_host_model

`default_nettype wire

// >>> testbench/tb_output_disable_pll_reset_regs.sv
`timescale 1ns/1ps
`default_nettype none

module tb_output_disable_pll_reset_regs;
	localparam logic [7:0] A_IDLE = clkgen_regs_pkg::IDLE_LEVEL_ADDR;
	localparam logic [7:0] A_PLL = clkgen_regs_pkg::PLL_RESTART_ADDR;
	localparam logic [7:0] A_XTAL = clkgen_regs_pkg::CRYSTAL_LOAD_ADDR;
	// Fields from output 7 down: never disabled, high impedance, high, low.
	localparam logic [7:0] IDLE_BYTE = 8'he4;

	logic i_core_clk = 1'b0;
	logic i_link_clk = 1'b0;
	logic i_rst_b = 1'b0;
	logic req, we, busy, done;
	logic [7:0] addr, wdata, rdata, r;
	logic [3:0] dis_reg = 4'h0;
	logic pin = 1'b0;
	logic [3:0] src = 4'h0;
	logic [3:0] clk_out, clk_oe;
	logic first_rs, second_rs;
	logic [1:0] xtal_sel;
	int n_fail = 0;
	int checks_done = 0;
	int n_first = 0;
	int n_second = 0;
	int base_first = 0;
	int base_second = 0;

	always #12.5 i_core_clk = ~i_core_clk;
	initial
	begin
		#7;
		forever #24 i_link_clk = ~i_link_clk;
	end

	always @(posedge i_core_clk)
	begin
		n_first += (first_rs === 1'b1);
		n_second += (second_rs === 1'b1);
	end

	output_disable_pll_reset_regs DUT (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b),
		.i_link_clk(i_link_clk), .i_link_req(req), .i_link_addr(addr), .i_link_wdata(wdata),
		.i_link_we(we), .o_link_busy(busy), .o_link_done(done), .o_link_rdata(rdata),
		.i_output_disable_reg(dis_reg), .i_output_disable_pin(pin), .i_clk_src(src),
		.o_clk_out(clk_out), .o_clk_out_oe(clk_oe), .o_first_pll_restart(first_rs),
		.o_second_pll_restart(second_rs), .o_crystal_load_select(xtal_sel));

	link_host_model host (.i_link_clk(i_link_clk), .i_link_busy(busy), .i_link_done(done),
		.i_link_rdata(rdata), .o_link_req(req), .o_link_addr(addr), .o_link_wdata(wdata),
		.o_link_we(we));

	task automatic print_verdict();
		$display("checks %0d failures %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic check8(input logic [7:0] got, input logic [7:0] exp, input string what);
		checks_done++;
		if (got !== exp)
		begin
			$display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
			n_fail++;
		end
	endtask

	task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d, input int gap);
		bit ok;
		host.access(w, a, d, gap, r, ok);
		if (!ok)
		begin
			$display("Error at %0t: link access got no answer", $time);
			n_fail++;
			print_verdict();
		end
	endtask

	task automatic out_case(input logic [3:0] s, input logic [3:0] dr, input logic p);
		logic [3:0] eo;
		logic [3:0] ee;
		logic [1:0] f;
		@(posedge i_core_clk);
		src <= s;
		dis_reg <= dr;
		pin <= p;
		repeat (6) @(posedge i_core_clk);
		for (int i = 0; i < 4; i++)
		begin
			f = IDLE_BYTE[2*i +: 2];
			eo[i] = s[i];
			ee[i] = 1'b1;
			if ((dr[i] || p) && f != 2'h3)
			begin
				eo[i] = (f == 2'h1);
				ee[i] = (f != 2'h2);
			end
		end
		check8({4'h0, clk_out}, {4'h0, eo}, "clock outputs");
		check8({4'h0, clk_oe}, {4'h0, ee}, "output enables");
	endtask

	initial
	begin
		repeat (16) @(posedge i_core_clk);
		i_rst_b <= 1'b1;
		xfer(1'b0, A_PLL, 8'h00, 0);
		check8(r, 8'h00, "restart reset value");
		xfer(1'b0, A_XTAL, 8'h00, 2);
		check8(r & 8'hc0, 8'hc0, "crystal reset value");
		check8({6'h00, xtal_sel}, 8'h03, "crystal select at reset");
		xfer(1'b0, 8'h42, 8'h00, 0);
		check8(r, 8'h00, "unmapped read");
		xfer(1'b1, A_IDLE, 8'h5a, 3);
		xfer(1'b0, A_IDLE, 8'h00, 0);
		check8(r, 8'h5a, "idle register readback");
		xfer(1'b1, 8'h42, 8'hff, 0);
		xfer(1'b0, A_IDLE, 8'h00, 0);
		check8(r, 8'h5a, "unmapped write ignored");
		$display("test reset and readback done");
		for (int k = 1; k < 4; k++)
		begin
			xfer(1'b1, A_XTAL, {2'(k), 6'h00}, k);
			xfer(1'b0, A_XTAL, 8'h00, 0);
			check8(r, {2'(k), 6'h00}, "crystal readback");
			check8({6'h00, xtal_sel}, {6'h00, 2'(k)}, "crystal select");
		end
		$display("test crystal load done");
		for (int k = 5; k < 8; k += 2)
		begin
			base_first = n_first;
			base_second = n_second;
			xfer(1'b1, A_PLL, 8'h01 << k, 0);
			repeat (6) @(posedge i_core_clk);
			check8(8'(n_first - base_first), {7'h00, k == 5}, "first restart pulses");
			check8(8'(n_second - base_second), {7'h00, k == 7}, "second restart pulses");
			xfer(1'b0, A_PLL, 8'h00, 1);
			check8(r, 8'h00, "restart bit cleared");
		end
		$display("test pll restart done");
		xfer(1'b1, A_IDLE, IDLE_BYTE, 0);
		for (int k = 0; k < 4; k++)
		begin
			out_case(4'h9 ^ {4{k[0]}}, 4'h0, 1'b0);
			out_case(4'h9 ^ {4{k[0]}}, 4'hf, 1'b0);
			out_case(4'h9 ^ {4{k[0]}}, 4'h1, 1'b0);
			out_case(4'h9 ^ {4{k[0]}}, 4'h0, 1'b1);
		end
		$display("test output disable done");
		print_verdict();
	end
endmodule // tb_output_disable_pll_reset_regs

`default_nettype wire
